/* File: logic/prc_pkg.sv */
// shared constants and types of the pll and periodic interrupt control
package prc_pkg;

  // register bus widths
  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_PLL_CONTROL = 2'h0;
  localparam logic [ADDR_W-1:0] OFS_RATE        = 2'h1;

  // pll control field positions
  localparam int unsigned BIT_MON   = 7;
  localparam int unsigned BIT_POWER = 6;
  localparam int unsigned BIT_AUTO  = 5;
  localparam int unsigned BIT_FILT  = 4;
  localparam int unsigned BIT_PRE   = 2;
  localparam int unsigned BIT_WDG   = 1;
  localparam int unsigned BIT_SELF  = 0;

  // rate register field positions
  localparam int unsigned PRE_LSB = 4;
  localparam int unsigned PRE_W   = 3;
  localparam int unsigned MOD_LSB = 0;
  localparam int unsigned MOD_W   = 4;
  localparam int unsigned RATE_W  = 7;

  // reset values
  localparam logic [DATA_W-1:0] PLL_CONTROL_RST = 8'hF1;
  localparam logic [RATE_W-1:0] RATE_RST        = 7'h00;

  // prescale code that turns the periodic interrupt off
  localparam logic [PRE_W-1:0] PRE_OFF = 3'h0;
  // exponent of the smallest prescale divide, reached at code one
  localparam int unsigned PRE_BASE_EXP = 10;
  // width of the periodic divider, large enough for 16 * 2^16
  localparam int unsigned PER_CNT_W = 21;

  // oscillator silence, in clk cycles, that counts as a lost clock
  localparam int unsigned CM_TIMEOUT_CYC = 64;

  // clock monitor states
  typedef enum logic [3:0]
  {
    CM_IDLE  = 4'b0001,
    CM_WATCH = 4'b0010,
    CM_SELF  = 4'b0100,
    CM_RESET = 4'b1000
  } prc_cm_state_t;

  // one register access of the cpu bus
  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } prc_bus_req_t;

  // operating mode inputs of the surrounding clock and reset logic
  typedef struct packed
  {
    logic sysclk_from_pll;
    logic pseudo_stop_sel;
    logic pll_stop_in_wait;
    logic stop_mode;
    logic wait_mode;
    logic special_mode;
    logic periodic_stop_in_wait;
    logic watchdog_stop_in_wait;
    logic freq_near;
  } prc_mode_t;

endpackage

/* File: logic/prc_clk_mon.sv */
// oscillator loss detector counting clk cycles between oscillator ticks
module prc_clk_mon
  import prc_pkg::*;
#(
  parameter int unsigned TIMEOUT = CM_TIMEOUT_CYC
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // control and sense
  input  wire logic arm,
  input  wire logic osc_tick,
  // result
  output logic      fail
);

  localparam int unsigned CW = $clog2(TIMEOUT + 1);
  localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT);

  logic [CW-1:0] gap_q;   // cycles since the last oscillator tick
  logic [CW-1:0] gap_d;
  logic          fail_q;  // oscillator deemed lost

  // restart on every tick, saturate at the limit
  assign gap_d = (!arm || osc_tick) ? '0 :
                 (gap_q == LIMIT) ? gap_q : gap_q + 1'b1;

  // gap counter and loss flag
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      gap_q  <= '0;
      fail_q <= 1'b0;
    end
    else
    begin
      gap_q  <= gap_d;
      fail_q <= arm && (gap_d == LIMIT);
    end
  end

  assign fail = fail_q;

endmodule

/* File: logic/prc_rti_div.sv */
// periodic interrupt divider counting oscillator ticks
module prc_per_div
  import prc_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // control
  input  wire logic [RATE_W-1:0] rate,
  input  wire logic              tick,
  input  wire logic              restart,
  // result
  output logic                   hit
);

  logic [PER_CNT_W-1:0] cnt_q;   // oscillator ticks in this period
  logic [PER_CNT_W-1:0] cnt_d;
  logic [PER_CNT_W-1:0] last;    // final count of the period
  logic [PRE_W-1:0]     pre;     // prescale code
  logic [MOD_W-1:0]     modu;    // modulus code
  logic                 off;     // interrupt switched off
  logic                 wrap;    // period ends on this tick
  logic                 hit_q;

  assign pre  = rate[PRE_LSB +: PRE_W];
  assign modu = rate[MOD_LSB +: MOD_W];
  assign off  = (pre == PRE_OFF);
  // period = (modulus + 1) * 2^(9 + prescale)
  assign last = ((PER_CNT_W'(modu) + 1'b1)
                 << (PRE_BASE_EXP - 1 + pre)) - 1'b1;
  assign wrap = tick && !off && (cnt_q == last);
  assign cnt_d = (restart || off || wrap) ? '0 :
                 tick ? cnt_q + 1'b1 : cnt_q;

  // counter and one-cycle period pulse
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt_q <= '0;
      hit_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      hit_q <= wrap && !restart;
    end
  end

  assign hit = hit_q;

endmodule

/* File: logic/prc_top.sv */
// pll control and periodic interrupt rate registers with their logic
//
// Contract
// - clock monitor enable locked during self-clock
// - enabled monitor reacts to lost oscillator
// - full stop disables the clock monitor
// - self-clock forces pll on, bit kept
// - pll power locked while system runs pll
// - powered pll with auto bandwidth locks alone
// - auto bit locked while pll stops in wait
// - auto chooses bandwidth, else manual bit
// - manual bit: 0 low, 1 high bandwidth
// - periodic counter runs in pseudo-stop if enabled
// - halted periodic dividers freeze, not reinitialised
// - watchdog runs in pseudo-stop if enabled
// - halted watchdog dividers freeze, not reinitialised
// - self-clock enable write-once in normal modes, never cleared in self-clock
// - loss: reset if disabled, self-clock if enabled
// - rate write restarts the periodic counter
// - prescale zero off, else 2^10 to 2^16
// - modulus multiplies divide by value plus one
// - periodic counter counts oscillator cycles
// - prescale resets to off
// - request while flag and enable both set
// - pll stop in wait forces auto to one
module prc_top
  import prc_pkg::*;
#(
  parameter int unsigned CM_TIMEOUT = CM_TIMEOUT_CYC
)
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // register port
  input  wire prc_bus_req_t       bus_req,
  output logic       [DATA_W-1:0] rd_data,
  // operating modes
  input  wire prc_mode_t          mode,
  // oscillator tick, one clk cycle per oscillator cycle
  input  wire logic               osc_tick,
  // periodic interrupt enable and flag clear
  input  wire logic               periodic_irq_en,
  input  wire logic               periodic_irq_clr,
  // pll controls
  output logic                    pll_power,
  output logic                    pll_bw_high,
  output logic                    pll_auto_bw,
  // clock monitor
  output logic                    clk_mon_armed,
  output logic                    self_clock_active,
  output logic                    clk_mon_reset,
  // watchdog divider controls
  output logic                    watchdog_tick_en,
  output logic                    watchdog_reinit,
  // periodic interrupt
  output logic                    periodic_irq_flag,
  output logic                    periodic_interrupt
);

  // decoded bus accesses
  wire wr_pll  = bus_req.wr && (bus_req.addr == OFS_PLL_CONTROL);
  wire wr_rate = bus_req.wr && (bus_req.addr == OFS_RATE);
  wire rd_any  = bus_req.rd;

  // write data bits, named for the fields they feed
  wire [DATA_W-1:0] wd = bus_req.wdata;

  // pll control register fields
  logic clk_monitor_en_q;            // clock monitor enable
  logic pll_power_on_q;              // latched pll power request
  logic auto_bw_q;                   // automatic bandwidth
  logic manual_acquire_q;            // manual filter choice
  logic periodic_run_pstop_q;        // periodic counter runs in pseudo-stop
  logic watchdog_run_pseudo_stop_q;  // watchdog runs in pseudo-stop
  logic self_clock_enable_q;         // self-clock on oscillator loss
  logic self_en_used_q;              // self-clock enable already written

  // next values of the pll control fields
  logic clk_monitor_en_d;
  logic pll_power_on_d;
  logic auto_bw_d;
  logic manual_acquire_d;
  logic periodic_run_pstop_d;
  logic watchdog_run_pseudo_stop_d;
  logic self_clock_enable_d;
  logic self_en_used_d;

  // periodic interrupt rate register
  logic [RATE_W-1:0] periodic_rate_sel_q;
  logic [RATE_W-1:0] periodic_rate_sel_d;

  // clock monitor state
  prc_cm_state_t cm_state_q;
  prc_cm_state_t cm_state_d;

  // periodic interrupt flag
  logic irq_flag_q;
  logic irq_flag_d;

  // registered outputs
  logic [DATA_W-1:0] rd_data_q;
  logic              pll_power_q;
  logic              pll_bw_high_q;
  logic              wdog_tick_q;
  logic              wdog_reinit_q;

  // internal status
  logic in_self;        // self-clock mode in force
  logic pstop_active;   // pseudo-stop in force
  logic full_stop;      // stop with the oscillator off
  logic osc_lost;       // clock monitor saw oscillator loss
  logic mon_arm;        // clock monitor allowed to look
  logic per_hit;        // periodic divider finished a period
  logic per_tick;       // periodic divider may count this cycle
  logic per_restart;    // periodic divider back to zero
  logic self_en_may_wr; // self-clock enable accepts this write

  // mode decode
  assign in_self      = (cm_state_q == CM_SELF);
  assign full_stop    = mode.stop_mode && !mode.pseudo_stop_sel;
  assign pstop_active = mode.stop_mode && mode.pseudo_stop_sel;

  // monitor looks only when enabled and not in full stop, even in self-clock
  assign mon_arm = (clk_monitor_en_q || in_self) && !full_stop;

  // clock monitor enable, locked while in self-clock mode
  assign clk_monitor_en_d = (wr_pll && !in_self) ? wd[BIT_MON]
                          : clk_monitor_en_q;

  // pll power, locked while the system clock comes from the pll
  assign pll_power_on_d = (wr_pll && !mode.sysclk_from_pll)
                        ? wd[BIT_POWER] : pll_power_on_q;

  // auto bandwidth, held at one while the pll stops in wait
  assign auto_bw_d = mode.pll_stop_in_wait ? 1'b1
                   : wr_pll ? wd[BIT_AUTO] : auto_bw_q;

  // manual filter choice, writable at any time
  assign manual_acquire_d = wr_pll ? wd[BIT_FILT]
                          : manual_acquire_q;

  // pseudo-stop run bits, writable at any time
  assign periodic_run_pstop_d = wr_pll ? wd[BIT_PRE]
                              : periodic_run_pstop_q;
  assign watchdog_run_pseudo_stop_d = wr_pll ? wd[BIT_WDG]
                                    : watchdog_run_pseudo_stop_q;

  // self-clock enable: once in normal modes, freely in special modes,
  // and a clear is refused while self-clock mode is in force
  assign self_en_may_wr = wr_pll
                       && (mode.special_mode || !self_en_used_q)
                       && !(in_self && !wd[BIT_SELF]);
  assign self_clock_enable_d = self_en_may_wr ? wd[BIT_SELF]
                             : self_clock_enable_q;
  // any write in a normal mode uses up the single chance
  assign self_en_used_d = self_en_used_q
                       || (wr_pll && !mode.special_mode);

  // rate register, writable at any time
  assign periodic_rate_sel_d = wr_rate ? wd[RATE_W-1:0]
                             : periodic_rate_sel_q;

  // register bank update
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      clk_monitor_en_q           <= PLL_CONTROL_RST[BIT_MON];
      pll_power_on_q             <= PLL_CONTROL_RST[BIT_POWER];
      auto_bw_q                  <= PLL_CONTROL_RST[BIT_AUTO];
      manual_acquire_q           <= PLL_CONTROL_RST[BIT_FILT];
      periodic_run_pstop_q       <= PLL_CONTROL_RST[BIT_PRE];
      watchdog_run_pseudo_stop_q <= PLL_CONTROL_RST[BIT_WDG];
      self_clock_enable_q        <= PLL_CONTROL_RST[BIT_SELF];
      self_en_used_q             <= 1'b0;
      periodic_rate_sel_q        <= RATE_RST;
    end
    else
    begin
      clk_monitor_en_q           <= clk_monitor_en_d;
      pll_power_on_q             <= pll_power_on_d;
      auto_bw_q                  <= auto_bw_d;
      manual_acquire_q           <= manual_acquire_d;
      periodic_run_pstop_q       <= periodic_run_pstop_d;
      watchdog_run_pseudo_stop_q <= watchdog_run_pseudo_stop_d;
      self_clock_enable_q        <= self_clock_enable_d;
      self_en_used_q             <= self_en_used_d;
      periodic_rate_sel_q        <= periodic_rate_sel_d;
    end
  end

  // read mux: bit 3 of the pll control and bit 7 of the rate register read zero
  wire [DATA_W-1:0] pll_rd = {clk_monitor_en_q,
                              pll_power_on_q,
                              auto_bw_q,
                              manual_acquire_q,
                              1'b0,
                              periodic_run_pstop_q,
                              watchdog_run_pseudo_stop_q,
                              self_clock_enable_q};
  wire [DATA_W-1:0] rate_rd = {1'b0, periodic_rate_sel_q};
  wire [DATA_W-1:0] rd_sel  =
    (bus_req.addr == OFS_PLL_CONTROL) ? pll_rd :
    (bus_req.addr == OFS_RATE)        ? rate_rd : '0;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rd_data_q <= '0;
    end
    else
    begin
      rd_data_q <= rd_any ? rd_sel : '0;
    end
  end

  // oscillator loss detector
  prc_clk_mon #(
    .TIMEOUT (CM_TIMEOUT)
  ) u_clk_mon (
    .clk      (clk),
    .nrst     (nrst),
    .arm      (mon_arm),
    .osc_tick (osc_tick),
    .fail     (osc_lost)
  );

  // clock monitor sequencing
  always_comb
  begin
    cm_state_d = cm_state_q;
    case (cm_state_q)
      // monitor disabled or in full stop
      CM_IDLE:
      begin
        if (mon_arm)
        begin
          cm_state_d = CM_WATCH;
        end
      end
      // watching the oscillator
      CM_WATCH:
      begin
        if (!mon_arm)
        begin
          cm_state_d = CM_IDLE;
        end
        else if (osc_lost)
        begin
          // loss leads to self-clock or to a reset
          cm_state_d = self_clock_enable_q ? CM_SELF
                                           : CM_RESET;
        end
      end
      // running on the self clock until the oscillator is back
      CM_SELF:
      begin
        if (!osc_lost)
        begin
          cm_state_d = CM_WATCH;
        end
      end
      // one cycle of reset request, then start over
      CM_RESET:
      begin
        cm_state_d = CM_IDLE;
      end
      default:
      begin
        cm_state_d = CM_IDLE;
      end
    endcase
  end

  // clock monitor state register
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cm_state_q <= CM_IDLE;
    end
    else
    begin
      cm_state_q <= cm_state_d;
    end
  end

  // periodic counter halts in pseudo-stop unless enabled, and a rate
  // write or wait mode with its stop bit reinitialises it
  assign per_tick    = osc_tick
                    && !(pstop_active && !periodic_run_pstop_q);
  assign per_restart = wr_rate
                    || (mode.wait_mode && mode.periodic_stop_in_wait);

  // periodic divider
  prc_per_div u_per_div (
    .clk     (clk),
    .nrst    (nrst),
    .rate    (periodic_rate_sel_q),
    .tick    (per_tick),
    .restart (per_restart),
    .hit     (per_hit)
  );

  // flag: a period end in the clearing cycle wins
  assign irq_flag_d = per_hit
                   || (irq_flag_q && !periodic_irq_clr);

  // pll power, bandwidth and watchdog controls
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      irq_flag_q    <= 1'b0;
      pll_power_q   <= 1'b0;
      pll_bw_high_q <= 1'b0;
      wdog_tick_q   <= 1'b0;
      wdog_reinit_q <= 1'b0;
    end
    else
    begin
      irq_flag_q    <= irq_flag_d;
      // self-clock keeps the pll powered whatever the bit holds
      pll_power_q   <= pll_power_on_q || in_self;
      // auto picks acquisition from the frequency error
      pll_bw_high_q <= auto_bw_q ? !mode.freq_near
                                 : manual_acquire_q;
      // watchdog freezes in pseudo-stop unless enabled
      wdog_tick_q   <= osc_tick
                    && !(pstop_active && !watchdog_run_pseudo_stop_q)
                    && !(mode.wait_mode && mode.watchdog_stop_in_wait);
      wdog_reinit_q <= mode.wait_mode && mode.watchdog_stop_in_wait;
    end
  end

  // outputs
  assign rd_data            = rd_data_q;
  assign pll_power          = pll_power_q;
  assign pll_bw_high        = pll_bw_high_q;
  assign pll_auto_bw        = auto_bw_q;
  assign clk_mon_armed      = mon_arm;
  assign self_clock_active  = in_self;
  assign clk_mon_reset      = (cm_state_q == CM_RESET);
  assign watchdog_tick_en   = wdog_tick_q;
  assign watchdog_reinit    = wdog_reinit_q;
  assign periodic_irq_flag  = irq_flag_q;
  assign periodic_interrupt = irq_flag_q && periodic_irq_en;

endmodule

/* File: tb/prc_assertions.sv */
// port checks of the pll and periodic interrupt control
module prc_assertions
  import prc_pkg::*;
#(
  parameter int unsigned CM_TIMEOUT = CM_TIMEOUT_CYC
)
(
  // clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // register port
  input wire prc_bus_req_t      bus_req,
  input wire logic [DATA_W-1:0] rd_data,
  // modes and oscillator
  input wire prc_mode_t         mode,
  input wire logic              osc_tick,
  input wire logic              periodic_irq_en,
  input wire logic              periodic_irq_clr,
  // pll controls
  input wire logic              pll_power,
  input wire logic              pll_bw_high,
  input wire logic              pll_auto_bw,
  // clock monitor
  input wire logic              clk_mon_armed,
  input wire logic              self_clock_active,
  input wire logic              clk_mon_reset,
  // watchdog and periodic interrupt
  input wire logic              watchdog_tick_en,
  input wire logic              watchdog_reinit,
  input wire logic              periodic_irq_flag,
  input wire logic              periodic_interrupt
);
  int unsigned quiet_q; // armed cycles without an oscillator tick

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // count quiet cycles, saturating just past the timeout
  always_ff @(posedge clk)
  begin
    if (!nrst || !clk_mon_armed || osc_tick)
      quiet_q <= 0;
    else if (quiet_q <= CM_TIMEOUT)
      quiet_q <= quiet_q + 1;
    else
      quiet_q <= quiet_q;
  end

  read_idle_a: assert property (!bus_req.rd |=> rd_data == 8'h00)
    else $error("read data not idle");
  unmapped_read_a: assert property (bus_req.rd && bus_req.addr[1]
    |=> rd_data == 8'h00) else $error("unmapped read not zero");
  irq_request_a: assert property (periodic_interrupt ==
    (periodic_irq_flag && periodic_irq_en)) else $error("bad request");
  full_stop_a: assert property (mode.stop_mode && !mode.pseudo_stop_sel
    |-> !clk_mon_armed) else $error("monitor armed in full stop");
  self_power_a: assert property (self_clock_active |=> pll_power)
    else $error("pll off in self-clock");
  auto_forced_a: assert property (mode.pll_stop_in_wait |=> pll_auto_bw)
    else $error("auto bit not forced");
  auto_bw_a: assert property (pll_auto_bw
    |=> pll_bw_high == !$past(mode.freq_near)) else $error("auto bw wrong");
  loss_react_a: assert property (quiet_q == CM_TIMEOUT
    |-> ##[0:6] (clk_mon_reset || self_clock_active))
    else $error("lost oscillator unanswered");
  flag_sticky_a: assert property ($fell(periodic_irq_flag)
    |-> $past(periodic_irq_clr)) else $error("flag fell without clear");
endmodule

bind prc_top prc_assertions #(.CM_TIMEOUT(CM_TIMEOUT)) u_chk
(
  .clk(clk), .nrst(nrst), .bus_req(bus_req), .rd_data(rd_data),
  .mode(mode), .osc_tick(osc_tick), .periodic_irq_en(periodic_irq_en),
  .periodic_irq_clr(periodic_irq_clr), .pll_power(pll_power),
  .pll_bw_high(pll_bw_high), .pll_auto_bw(pll_auto_bw),
  .clk_mon_armed(clk_mon_armed), .self_clock_active(self_clock_active),
  .clk_mon_reset(clk_mon_reset), .watchdog_tick_en(watchdog_tick_en),
  .watchdog_reinit(watchdog_reinit), .periodic_irq_flag(periodic_irq_flag),
  .periodic_interrupt(periodic_interrupt)
);

/* File: tb/tb_top.sv */
// self-checking bench of the pll and periodic interrupt control
module tb_top
  import prc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // design ports
  logic              clk;
  logic              nrst;
  prc_bus_req_t      bus_req;
  logic [DATA_W-1:0] rd_data;
  prc_mode_t         mode;
  logic              osc_tick;
  logic              periodic_irq_en;
  logic              periodic_irq_clr;
  logic              pll_power, pll_bw_high, pll_auto_bw;
  logic              clk_mon_armed, self_clock_active, clk_mon_reset;
  logic              watchdog_tick_en, watchdog_reinit;
  logic              periodic_irq_flag, periodic_interrupt;
  // bench state
  logic [7:0]        exp_q[$];   // expected read answers
  logic              rd_seen;    // an answer is due this cycle
  logic              osc_run;    // oscillator running
  logic              osc_half;   // oscillator at half rate
  logic              ev_r, ev_s; // monitor reset or self-clock seen
  logic [7:0]        r;
  int                bad_count, n_compared, cyc;

  prc_top #(.CM_TIMEOUT(8)) dut
  (
    .clk(clk), .nrst(nrst), .bus_req(bus_req), .rd_data(rd_data),
    .mode(mode), .osc_tick(osc_tick), .periodic_irq_en(periodic_irq_en),
    .periodic_irq_clr(periodic_irq_clr), .pll_power(pll_power),
    .pll_bw_high(pll_bw_high), .pll_auto_bw(pll_auto_bw),
    .clk_mon_armed(clk_mon_armed), .self_clock_active(self_clock_active),
    .clk_mon_reset(clk_mon_reset), .watchdog_tick_en(watchdog_tick_en),
    .watchdog_reinit(watchdog_reinit), .periodic_irq_flag(periodic_irq_flag),
    .periodic_interrupt(periodic_interrupt)
  );

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // oscillator ticks and a wandering frequency error
  always @(posedge clk)
  begin
    osc_tick <= osc_run && (!osc_half || !osc_tick);
    mode.freq_near <= 1'($urandom);
  end

  // compare each read answer with the oldest note; cut a hang short
  always @(posedge clk)
  begin
    if (rd_seen)
      check(rd_data, exp_q.pop_front());
    rd_seen = bus_req.rd;
    cyc++;
    if (cyc == 60000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  // count and report one comparison
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // one write cycle
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask

  // one read cycle, answer noted for the monitor
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
  endtask

  // silence the oscillator and note what the monitor does
  task automatic lose();
    @(negedge clk);
    osc_run = 1'b0;
    ev_r = 1'b0;
    ev_s = 1'b0;
    repeat (40)
    begin
      @(negedge clk);
      ev_r |= clk_mon_reset;
      ev_s |= self_clock_active;
    end
  endtask

  // restart the oscillator and let the monitor settle
  task automatic resume();
    @(negedge clk);
    osc_run = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  // wait for the flag about p cycles on, then clear it
  task automatic measure(input int p);
    int   n;
    logic en;
    n = 0;
    en = 1'($urandom);
    periodic_irq_en <= en;
    while (periodic_irq_flag !== 1'b1 && n < p + 7)
    begin
      @(negedge clk);
      n++;
    end
    check(n >= p - 8 && n <= p + 6, 1'b1);
    check(periodic_interrupt, en);
    @(posedge clk) periodic_irq_clr <= 1'b1;
    @(posedge clk) periodic_irq_clr <= 1'b0;
    @(negedge clk);
    check(periodic_irq_flag, 1'b0);
  endtask

  // print the counts and the verdict, then stop
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    void'($urandom(32'hA2C7C32D));
    clk = 1'b0;
    nrst = 1'b0;
    bus_req = '0;
    mode = '0;
    osc_tick = 1'b0;
    osc_run = 1'b1;
    osc_half = 1'b0;
    periodic_irq_en = 1'b0;
    periodic_irq_clr = 1'b0;
    rd_seen = 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    // reset values and an unmapped place
    rd(OFS_PLL_CONTROL, PLL_CONTROL_RST);
    rd(OFS_RATE, 8'h00);
    rd(2'h2, 8'h00);
    // power bit locked, the rest lands, first write takes self-clock enable
    mode.sysclk_from_pll <= 1'b1;
    wr(OFS_PLL_CONTROL, 8'h00);
    rd(OFS_PLL_CONTROL, 8'h40);
    mode.sysclk_from_pll <= 1'b0;
    mode.pll_stop_in_wait <= 1'b1;
    wr(OFS_PLL_CONTROL, 8'h40);
    rd(OFS_PLL_CONTROL, 8'h60);
    mode.pll_stop_in_wait <= 1'b0;
    wr(OFS_PLL_CONTROL, 8'h11);
    rd(OFS_PLL_CONTROL, 8'h10);
    @(negedge clk);
    check(pll_bw_high, 1'b1);
    // special mode: self-clock enable freely writable
    @(posedge clk) mode.special_mode <= 1'b1;
    wr(OFS_PLL_CONTROL, 8'h81);
    rd(OFS_PLL_CONTROL, 8'h81);
    lose();
    check({ev_r, ev_s}, 2'b01);
    check(pll_power, 1'b1);
    wr(OFS_PLL_CONTROL, 8'h00);
    rd(OFS_PLL_CONTROL, 8'h81);
    resume();
    check(self_clock_active, 1'b0);
    // loss with self-clock disabled asks for a reset
    wr(OFS_PLL_CONTROL, 8'h80);
    lose();
    check({ev_r, ev_s}, 2'b10);
    resume();
    // full stop blinds the monitor
    @(posedge clk) mode.stop_mode <= 1'b1;
    lose();
    check({ev_r, ev_s, clk_mon_armed}, 3'b000);
    resume();
    @(posedge clk) mode.stop_mode <= 1'b0;
    // every prescale code, short periods timed, code zero stays off
    for (int c = 0; c < 8; c++)
    begin
      r = {1'($urandom), 3'(c), 4'($urandom_range(0, 1))};
      wr(OFS_RATE, r);
      rd(OFS_RATE, r & 8'h7F);
      if (c == 0)
      begin
        repeat (3000) @(negedge clk);
        check(periodic_irq_flag, 1'b0);
      end
      else if (c < 4)
        measure(((int'(r[3:0]) + 1) << (9 + c)) - 3);
    end
    // top modulus, restarted part way by a second write
    wr(OFS_RATE, 8'h1F);
    repeat (900) @(posedge clk);
    wr(OFS_RATE, 8'h1F);
    measure(16384);
    // only oscillator ticks are counted
    osc_half <= 1'b1;
    wr(OFS_RATE, 8'h10);
    measure(2048);
    osc_half <= 1'b0;
    // pseudo-stop with both enables clear freezes the dividers
    wr(OFS_RATE, 8'h10);
    repeat (500) @(posedge clk);
    mode.stop_mode <= 1'b1;
    mode.pseudo_stop_sel <= 1'b1;
    repeat (300) @(negedge clk);
    check(watchdog_tick_en, 1'b0);
    @(posedge clk) mode.stop_mode <= 1'b0;
    measure(524);
    check(watchdog_tick_en, 1'b1);
    // wait mode with both stop bits holds and reinitialises the dividers
    @(posedge clk) mode.wait_mode <= 1'b1;
    mode.watchdog_stop_in_wait <= 1'b1;
    mode.periodic_stop_in_wait <= 1'b1;
    repeat (1100) @(negedge clk);
    check({watchdog_reinit, watchdog_tick_en}, 2'b10);
    check(periodic_irq_flag, 1'b0);
    @(posedge clk) mode.wait_mode <= 1'b0;
    measure(1026);
    report_and_stop();
  end
endmodule
